// ==== ofp_host_model.sv ====
// Two-wire host controller model that programs the oscillator over the serial port
`timescale 1ns/10ps
`default_nettype none
module ofp_host_model (
   input  wire logic mclk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_o
);
   // Clock stands high and data is released between frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic hc();
      repeat (8) @(negedge mclk_i);
   endtask
   // Data moves only while the clock is low
   task automatic bt(input logic b, output logic r);
      sda_o = b;
      hc();
      scl_o = 1'b1;
      hc();
      r = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic by(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
      bt(m, a);
   endtask
   task automatic st();
      sda_o = 1'b1;
      hc();
      scl_o = 1'b1;
      hc();
      sda_o = 1'b0;
      hc();
      scl_o = 1'b0;
   endtask
   task automatic sp();
      sda_o = 1'b0;
      hc();
      scl_o = 1'b1;
      hc();
      sda_o = 1'b1;
      hc();
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      st();
      by({7'h55, 1'b0}, 1'b1, r, a0);
      by(ra, 1'b1, r, a1);
      by(d, 1'b1, r, a2);
      sp();
      ok = !(a0 | a1 | a2);
   endtask
   task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic       a0, a1, a2;
      st();
      by({7'h55, 1'b0}, 1'b1, r, a0);
      by(ra, 1'b1, r, a1);
      st();
      by({7'h55, 1'b1}, 1'b1, r, a2);
      ok = !(a0 | a1 | a2);
      by(8'hFF, 1'b1, d, a0);
      sp();
   endtask
endmodule // ofp_host_model
`default_nettype wire

// ==== ofp_pkg.sv ====
// Shared constants, register map and types for the oscillator frequency programming block
package ofp_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_KHZ      = 40000;
   localparam int RECAL_MAX_MS = 10;
   localparam int RECAL_CYCLES = RECAL_MAX_MS * CLK_KHZ;

   // ****************************************
   // Core oscillator limits and window
   // ****************************************
   localparam int          FDCO_MIN_MHZ    = 4850;
   localparam int          FDCO_MAX_MHZ    = 5670;
   localparam int          KHZ_PER_MHZ     = 1000;
   localparam logic [63:0] FXTAL_KHZ       = 64'h000000000001BE6D;
   localparam int          PPM_WINDOW      = 3500;
   localparam int          PPM_SCALE       = 1000000;
   localparam int          FRACTIONAL_MULTIPLIER_W         = 38;
   localparam int          FRACTIONAL_MULTIPLIER_INT_BITS  = 10;
   localparam int          FRACTIONAL_MULTIPLIER_FRAC_BITS = 28;
   localparam logic [63:0] FDCO_MIN_FIX    =
      (64'(FDCO_MIN_MHZ) * 64'(KHZ_PER_MHZ)) << FRACTIONAL_MULTIPLIER_FRAC_BITS;
   localparam logic [63:0] FDCO_MAX_FIX    =
      (64'(FDCO_MAX_MHZ) * 64'(KHZ_PER_MHZ)) << FRACTIONAL_MULTIPLIER_FRAC_BITS;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_BANK_STD   = 8'h07;
   localparam logic [7:0] ADDR_BANK_HI    = 8'h0D;
   localparam int         BANK_BYTES      = 6;
   localparam logic [7:0] ADDR_FREQ_CTRL  = 8'h87;
   localparam logic [7:0] ADDR_CORE_CTRL  = 8'h89;
   localparam int         HOLD_MULT_BIT   = 5;
   localparam int         APPLY_NEW_BIT   = 6;
   localparam int         FREEZE_CORE_BIT = 4;

   // Bank word layout, first byte is most significant
   localparam int HS_MSB = 47;
   localparam int HS_LSB = 45;
   localparam int N1_MSB = 44;
   localparam int N1_LSB = 38;
   localparam logic [3:0] HS_OFFSET = 4'h4;
   localparam logic [7:0] N1_OFFSET = 8'h01;

   // Factory default configuration
   localparam logic [2:0]         DEF_HS_CODE = 3'h0;
   localparam logic [6:0]         DEF_N1_CODE = 7'h07;
   localparam logic [FRACTIONAL_MULTIPLIER_W-1:0] DEF_FRACTIONAL_MULTIPLIER   = 38'h2BC011EB8;
   localparam logic [47:0]        DEF_WORD    = {DEF_HS_CODE, DEF_N1_CODE, DEF_FRACTIONAL_MULTIPLIER};

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       stb;
      logic [7:0] addr;
      logic [7:0] data;
   } ofp_wr_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_RECAL = 2'b10
   } ofp_core_st_t;

   typedef enum logic [4:0] {
      SL_IDLE = 5'b00001,
      SL_RX   = 5'b00010,
      SL_ACK  = 5'b00100,
      SL_TX   = 5'b01000,
      SL_RACK = 5'b10000
   } ofp_sl_st_t;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_PTR  = 2'b01,
      PH_DATA = 2'b10
   } ofp_phase_t;

endpackage

// ==== ofp_serial_slave.sv ====
// Two-wire serial port slave: byte framing, register pointer, read address and write strobe
`timescale 1ns/10ps
`default_nettype none
module ofp_serial_slave
   import ofp_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h55
) (
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] rd_data_i,
   output var  logic       sda_oen_o,
   output var  ofp_wr_t    wr_o,
   output var  logic [7:0] rd_addr_o
);

   logic       scl_s1_reg;
   logic       scl_s2_reg;
   logic       scl_d_reg;
   logic       sda_s1_reg;
   logic       sda_s2_reg;
   logic       sda_d_reg;
   ofp_sl_st_t st_reg;
   ofp_phase_t phase_reg;
   logic [3:0] cnt_reg;
   logic [7:0] sh_reg;
   logic       rw_reg;
   logic       ack_ok_reg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg  <= 1'b1;
      end else begin
         scl_s1_reg <= scl_i;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg  <= scl_s2_reg;
         sda_s1_reg <= sda_i;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg  <= sda_s2_reg;
      end
   end

   assign scl_rise  = scl_s2_reg & ~scl_d_reg;
   assign scl_fall  = ~scl_s2_reg & scl_d_reg;
   assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   // ****************************************
   // Byte engine
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_reg     <= SL_IDLE;
         phase_reg  <= PH_ADDR;
         cnt_reg    <= 4'h0;
         sh_reg     <= 8'h00;
         rw_reg     <= 1'b0;
         ack_ok_reg <= 1'b0;
         sda_oen_o  <= 1'b1;
         wr_o       <= '0;
         rd_addr_o  <= 8'h00;
      end else begin
         wr_o.stb <= 1'b0;
         if (start_det) begin
            st_reg    <= SL_RX;
            phase_reg <= PH_ADDR;
            cnt_reg   <= 4'h0;
            sda_oen_o <= 1'b1;
         end else if (stop_det) begin
            st_reg    <= SL_IDLE;
            sda_oen_o <= 1'b1;
         end else begin
            case (st_reg)
               SL_RX: begin
                  if (scl_rise) begin
                     sh_reg  <= {sh_reg[6:0], sda_s2_reg};
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (scl_fall && cnt_reg == 4'h8) begin
                     cnt_reg <= 4'h0;
                     case (phase_reg)
                        PH_ADDR: begin
                           if (sh_reg[7:1] == SLAVE_ADDR) begin
                              rw_reg    <= sh_reg[0];
                              phase_reg <= PH_PTR;
                              sda_oen_o <= 1'b0;
                              st_reg    <= SL_ACK;
                           end else begin
                              st_reg <= SL_IDLE;
                           end
                        end
                        PH_PTR: begin
                           rd_addr_o <= sh_reg;
                           phase_reg <= PH_DATA;
                           sda_oen_o <= 1'b0;
                           st_reg    <= SL_ACK;
                        end
                        default: begin
                           // Pointer advances so multi-byte writes fill a bank in order
                           wr_o      <= '{stb: 1'b1, addr: rd_addr_o, data: sh_reg};
                           rd_addr_o <= rd_addr_o + 8'h01;
                           sda_oen_o <= 1'b0;
                           st_reg    <= SL_ACK;
                        end
                     endcase
                  end
               end
               SL_ACK: begin
                  if (scl_fall) begin
                     if (rw_reg) begin
                        sh_reg    <= rd_data_i;
                        rd_addr_o <= rd_addr_o + 8'h01;
                        sda_oen_o <= rd_data_i[7];
                        cnt_reg   <= 4'h0;
                        st_reg    <= SL_TX;
                     end else begin
                        sda_oen_o <= 1'b1;
                        st_reg    <= SL_RX;
                     end
                  end
               end
               SL_TX: begin
                  if (scl_fall) begin
                     if (cnt_reg == 4'h7) begin
                        sda_oen_o <= 1'b1;
                        st_reg    <= SL_RACK;
                     end else begin
                        sh_reg    <= {sh_reg[6:0], 1'b0};
                        sda_oen_o <= sh_reg[6];
                        cnt_reg   <= cnt_reg + 4'h1;
                     end
                  end
               end
               SL_RACK: begin
                  if (scl_rise) begin
                     ack_ok_reg <= ~sda_s2_reg;
                  end else if (scl_fall) begin
                     if (ack_ok_reg) begin
                        sh_reg    <= rd_data_i;
                        rd_addr_o <= rd_addr_o + 8'h01;
                        sda_oen_o <= rd_data_i[7];
                        cnt_reg   <= 4'h0;
                        st_reg    <= SL_TX;
                     end else begin
                        st_reg <= SL_IDLE;
                     end
                  end
               end
               default: begin
                  sda_oen_o <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule // ofp_serial_slave
`default_nettype wire

// ==== ofp_top.sv ====
// Oscillator frequency programming: multiplier bank, hold and freeze, recalibration, output clock
//
// Functional notes
// R1: Output frequency is crystal times multiplier over the two dividers' product.
// R2: Core frequency is the fixed crystal frequency times the multiplier.
// R3: Core stays within 4.85 to 5.67 GHz using a 38-bit multiplier.
// R4: Changes within 3500 ppm of center keep the output running uninterrupted.
// R5: Larger changes recalibrate; output stops up to 10 ms, restarts arbitrary phase.
// R6: A finished recalibration makes the new setting the new center.
// R7: Glitch-sensitive downstream logic should be reset after recalibration.
// R8: Device starts at a factory default, changeable over the serial port.
// R9: Power cycling discards programming and restores the factory default.
// R10: Host changes only the multiplier for small changes, dividers untouched.
// R11: Multiplier bank at 7 to 12, or 13 to 18 on tight variant.
// R12: Host scales the current multiplier by new over current frequency.
// R13: Host computes multiplier with at least 38 bits of precision.
// R14: Without hold, each written multiplier byte takes effect on arrival.
// R15: Control 135 bit 5 set holds the multiplier in effect.
// R16: While held, host writes the complete new multiplier.
// R17: Clearing bit 5 releases the hold and applies the whole word at once.
// R18: Bit 4 of register 137 freezes the core for large changes.
// R19: Host unfreezes and sets bit 6 of 135 within the timeout.
// R20: Host picks high-speed divider 4,5,6,7,9,11; output divider 1 or even.
// R21: Multiplier has 10 integer bits above 28 fraction bits.
`timescale 1ns/10ps
`default_nettype none
module ofp_top
   import ofp_pkg::*;
#(
   parameter int         RECAL_CYCLES_P = RECAL_CYCLES,
   parameter logic       HIGH_STAB      = 1'b0,
   parameter logic [6:0] SLAVE_ADDR     = 7'h55  // Arbitrary bus address
) (
   input  wire logic mclk_i,
   input  wire logic rstn_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output var  logic sda_o,
   output var  logic sda_oen_o,
   output var  logic clk_out_o,
   output var  logic recal_busy_o
);

   localparam logic [7:0] BANK_BASE = HIGH_STAB ? ADDR_BANK_HI : ADDR_BANK_STD;

   ofp_wr_t              wr;
   logic [7:0]           rd_addr;
   logic [7:0]           rd_data_reg;
   logic [7:0]           stage_reg [BANK_BYTES];
   logic [47:0]          stage_word;
   logic [FRACTIONAL_MULTIPLIER_W-1:0]   st_fractional_multiplier;
   logic [2:0]           st_hs;
   logic [6:0]           st_n1;
   logic                 hold_mult_reg;
   logic                 apply_new_reg;
   logic                 freeze_core_reg;
   ofp_core_st_t         core_st_reg;
   logic [23:0]          recal_cnt_reg;
   logic [FRACTIONAL_MULTIPLIER_W-1:0]   act_fractional_multiplier_reg;
   logic [2:0]           act_hs_reg;
   logic [6:0]           act_n1_reg;
   logic [FRACTIONAL_MULTIPLIER_W-1:0]   center_reg;
   logic [FRACTIONAL_MULTIPLIER_W-1:0]   acc_reg;
   logic [FRACTIONAL_MULTIPLIER_W:0]     acc_sum;
   logic [11:0]          div_total;
   logic [11:0]          div_cnt_reg;
   logic [11:0]          div_cnt_next;
   logic [FRACTIONAL_MULTIPLIER_W-1:0]   dev;
   logic [7:0]           wr_idx;
   logic [7:0]           rd_idx;
   logic                 wr_ctrl;
   logic                 wr_core;
   logic                 small_step;
   logic                 div_same;
   logic                 differs;
   logic                 st_ok;
   logic                 recal_done;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic core_in_range(input logic [FRACTIONAL_MULTIPLIER_W-1:0] m);
      logic [63:0] f;
      f = 64'(m) * FXTAL_KHZ;
      return (f >= FDCO_MIN_FIX) && (f <= FDCO_MAX_FIX);
   endfunction

   // ****************************************
   // Serial port
   // ****************************************
   ofp_serial_slave #(
      .SLAVE_ADDR (SLAVE_ADDR)
   ) u_slave (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .rd_data_i (rd_data_reg),
      .sda_oen_o (sda_oen_o),
      .wr_o      (wr),
      .rd_addr_o (rd_addr)
   );

   // Open-drain: only ever drives low
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   assign wr_idx  = wr.addr - BANK_BASE;  // R11
   assign rd_idx  = rd_addr - BANK_BASE;
   assign wr_ctrl = wr.stb && (wr.addr == ADDR_FREQ_CTRL);
   assign wr_core = wr.stb && (wr.addr == ADDR_CORE_CTRL);

   // Reset is the power cycle: programming is lost, default returns
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < BANK_BYTES; i++) begin
            stage_reg[i] <= DEF_WORD[47-8*i -: 8];  // R8 R9
         end
      end else if (wr.stb && wr_idx < 8'(BANK_BYTES)) begin
         stage_reg[wr_idx[2:0]] <= wr.data;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold_mult_reg   <= 1'b0;
         freeze_core_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            hold_mult_reg <= wr.data[HOLD_MULT_BIT];  // R15 R17
         end
         if (wr_core) begin
            freeze_core_reg <= wr.data[FREEZE_CORE_BIT];  // R18
         end
      end
   end

   // Software set wins over the completion clear
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         apply_new_reg <= 1'b0;
      end else if (wr_ctrl && wr.data[APPLY_NEW_BIT]) begin
         apply_new_reg <= 1'b1;
      end else if (recal_done) begin
         apply_new_reg <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_reg <= 8'h00;
      end else if (rd_idx < 8'(BANK_BYTES)) begin
         rd_data_reg <= stage_reg[rd_idx[2:0]];
      end else if (rd_addr == ADDR_FREQ_CTRL) begin
         rd_data_reg <= 8'(({7'h00, apply_new_reg} << APPLY_NEW_BIT)
                         | ({7'h00, hold_mult_reg} << HOLD_MULT_BIT));
      end else if (rd_addr == ADDR_CORE_CTRL) begin
         rd_data_reg <= 8'({7'h00, freeze_core_reg} << FREEZE_CORE_BIT);
      end else begin
         rd_data_reg <= 8'h00;
      end
   end

   // ****************************************
   // Change classification
   // ****************************************
   assign stage_word = {stage_reg[0], stage_reg[1], stage_reg[2],
                        stage_reg[3], stage_reg[4], stage_reg[5]};
   assign st_fractional_multiplier   = stage_word[FRACTIONAL_MULTIPLIER_W-1:0];  // R21
   assign st_hs      = stage_word[HS_MSB:HS_LSB];
   assign st_n1      = stage_word[N1_MSB:N1_LSB];
   assign dev        = (st_fractional_multiplier >= center_reg) ? st_fractional_multiplier - center_reg
                                                : center_reg - st_fractional_multiplier;
   assign small_step = 64'(dev) * 64'(PPM_SCALE) <= 64'(center_reg) * 64'(PPM_WINDOW);  // R4
   assign div_same   = (st_hs == act_hs_reg) && (st_n1 == act_n1_reg);
   assign differs    = (st_fractional_multiplier != act_fractional_multiplier_reg) || !div_same;
   assign st_ok      = core_in_range(st_fractional_multiplier);  // R3
   assign recal_done = (core_st_reg == ST_RECAL)
                       && (recal_cnt_reg == 24'(RECAL_CYCLES_P - 1));

   // ****************************************
   // Core control
   // ****************************************
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         core_st_reg   <= ST_RUN;
         recal_cnt_reg <= 24'h000000;
         act_fractional_multiplier_reg <= DEF_FRACTIONAL_MULTIPLIER;  // R8 R9
         act_hs_reg    <= DEF_HS_CODE;
         act_n1_reg    <= DEF_N1_CODE;
         center_reg    <= DEF_FRACTIONAL_MULTIPLIER;
         recal_busy_o  <= 1'b0;
      end else begin
         case (core_st_reg)
            ST_RUN: begin
               recal_cnt_reg <= 24'h000000;
               if (!freeze_core_reg && apply_new_reg) begin
                  core_st_reg  <= ST_RECAL;  // R18
                  recal_busy_o <= 1'b1;
               end else if (!freeze_core_reg && !hold_mult_reg && differs && st_ok) begin
                  if (small_step && div_same) begin
                     act_fractional_multiplier_reg <= st_fractional_multiplier;  // R4 R14
                  end else begin
                     core_st_reg  <= ST_RECAL;  // R5
                     recal_busy_o <= 1'b1;
                  end
               end
            end
            ST_RECAL: begin
               recal_cnt_reg <= recal_cnt_reg + 24'h000001;
               if (recal_done) begin
                  // Out-of-range staging keeps the old setting as the center
                  if (st_ok) begin
                     act_fractional_multiplier_reg <= st_fractional_multiplier;
                     act_hs_reg    <= st_hs;
                     act_n1_reg    <= st_n1;
                     center_reg    <= st_fractional_multiplier;  // R6
                  end else begin
                     center_reg <= act_fractional_multiplier_reg;
                  end
                  core_st_reg  <= ST_RUN;
                  recal_busy_o <= 1'b0;
               end
            end
            default: begin
               core_st_reg  <= ST_RUN;
               recal_busy_o <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************
   // Core oscillator model and output divider
   // ****************************************
   // Crystal scaled to mclk/2^10 so one core tick never exceeds one cycle
   assign acc_sum      = {1'b0, acc_reg} + {1'b0, act_fractional_multiplier_reg};  // R2
   assign div_total    = 12'(4'(act_hs_reg) + HS_OFFSET) * 12'(8'(act_n1_reg) + N1_OFFSET);
   assign div_cnt_next = (div_cnt_reg == div_total - 12'h001) ? 12'h000
                                                              : div_cnt_reg + 12'h001;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_reg <= '0;
      end else begin
         acc_reg <= acc_sum[FRACTIONAL_MULTIPLIER_W-1:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_cnt_reg <= 12'h000;
         clk_out_o   <= 1'b0;
      end else if (core_st_reg != ST_RUN) begin
         div_cnt_reg <= 12'h000;  // R5
         clk_out_o   <= 1'b0;
      end else if (acc_sum[FRACTIONAL_MULTIPLIER_W]) begin
         div_cnt_reg <= div_cnt_next;  // R1
         clk_out_o   <= div_cnt_next < (div_total >> 1);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   AST_CLK_STOPS_RECAL: assert property (  // R5
      core_st_reg == ST_RECAL |=> !clk_out_o)
      else $error("output clock ran during recalibration");

   AST_RECAL_MIN_LEN: assert property (  // R5
      $rose(core_st_reg == ST_RECAL) |-> (core_st_reg == ST_RECAL && recal_busy_o)[*8])
      else $error("recalibration ended too early");

   AST_NEW_CENTER: assert property (  // R6
      $fell(core_st_reg == ST_RECAL) |-> center_reg == act_fractional_multiplier_reg)
      else $error("center not updated after recalibration");

   AST_SMALL_STEP: assert property (  // R4
      core_st_reg == ST_RUN && !freeze_core_reg && !hold_mult_reg && !apply_new_reg
      && differs && st_ok && small_step && div_same
      |=> core_st_reg == ST_RUN && act_fractional_multiplier_reg == $past(st_fractional_multiplier))
      else $error("small change interrupted or not applied");

   AST_HOLD_KEEPS: assert property (  // R15
      hold_mult_reg && core_st_reg == ST_RUN |=> $stable(act_fractional_multiplier_reg))
      else $error("multiplier changed while held");

   AST_FREEZE_CORE: assert property (  // R18
      freeze_core_reg && core_st_reg == ST_RUN
      |=> core_st_reg == ST_RUN && $stable(act_fractional_multiplier_reg) && $stable(act_hs_reg))
      else $error("core changed while frozen");

   AST_CORE_RANGE: assert property (  // R3
      core_st_reg == ST_RUN |-> core_in_range(act_fractional_multiplier_reg))
      else $error("core frequency out of range");

   AST_DIV_BOUND: assert property (  // R1
      acc_sum[FRACTIONAL_MULTIPLIER_W] && core_st_reg == ST_RUN |=> div_cnt_reg < div_total)
      else $error("output divider count out of bounds");

   AST_APPLY_CLEARS: assert property (  // R6
      recal_done && !(wr_ctrl && wr.data[APPLY_NEW_BIT]) |=> !apply_new_reg)
      else $error("apply bit not cleared after recalibration");

endmodule // ofp_top
`default_nettype wire

// ==== oscillator_freq_programming_tb.sv ====
// Self-checking bench for the oscillator frequency programming block
`timescale 1ns/10ps
`default_nettype none
module oscillator_freq_programming_tb;
   import ofp_pkg::*;
   localparam int RC = 16;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic scl, hsda, sda_o, sda_oen_o, clk_out_o, recal_busy_o;
   logic clk_q = 1'b0;
   wire  logic sda_w = hsda & (sda_oen_o | sda_o);
   int bad_count = 0, checks = 0, recals = 0, rlen = 0, runt = 0, prd = 0, last_prd = 0, edges = 0;
   always #12.5 mclk_i = ~mclk_i;
   ofp_top #(.RECAL_CYCLES_P(RC)) DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oen_o(sda_oen_o), .clk_out_o(clk_out_o),
      .recal_busy_o(recal_busy_o));
   ofp_host_model host (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
   // ****************************************
   // Output clock and recalibration monitor
   // ****************************************
   always @(posedge mclk_i) begin
      prd++;
      if (clk_out_o !== clk_q) edges++;
      if (clk_out_o === 1'b1 && clk_q === 1'b0) begin
         last_prd = prd;
         prd = 0;
      end
      clk_q = clk_out_o;
      if (recal_busy_o === 1'b1) begin
         rlen++;
         // Output stops one cycle after busy rises, so the first busy cycle may still be high
         if (clk_out_o !== 1'b0 && rlen > 1) runt++;
      end else if (rlen != 0) begin
         recals++;
         chk_n(rlen, RC);
         rlen = 0;
      end
   end
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: byte %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk_n(input int g, input int e);
      checks++;
      if (g != e) begin
         bad_count++;
         $display("wrong value at %0t: count %0d expected %0d", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      host.wr(a, d, ok);
      chk8({7'h00, ok}, 8'h01);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      chk8({7'h00, ok}, 8'h01);
      chk8(d, e);
   endtask
   function automatic int exp_prd(input int dv, input logic [37:0] rf);
      return int'((longint'(dv) << 38) / longint'(rf));
   endfunction
   // Two full output periods after the last change
   task automatic prdk(input int dv, input logic [37:0] rf);
      int e0;
      e0 = edges;
      // Restart period skipped, as a downstream user would after recalibration
      for (int k = 0; k < 5000 && edges < e0 + 5; k++) @(posedge mclk_i);
      chk_n(edges >= e0 + 5, 1);
      chk_n(last_prd - exp_prd(dv, rf) inside {[-1:1]}, 1);
   endtask
   task automatic rst();
      rstn_i = 1'b0;
      repeat (16) @(negedge mclk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge mclk_i);
   endtask
   task automatic t_default();
      for (int i = 0; i < 6; i++) rdc(8'h07 + 8'(i), DEF_WORD[47 - 8*i -: 8]);
      rdc(8'h87, 8'h00);
      rdc(8'h20, 8'h00);
      prdk(32, DEF_FRACTIONAL_MULTIPLIER);
   endtask
   task automatic t_small();
      int r0, e0;
      r0 = recals;
      e0 = edges;
      wr(8'h0A, 8'h20);
      chk_n(recals, r0);
      chk_n(edges > e0, 1);
      rdc(8'h0A, 8'h20);
   endtask
   task automatic t_hold();
      int r0;
      r0 = recals;
      wr(8'h87, 8'h20);
      wr(8'h09, 8'hC0);
      chk_n(recals, r0);
      wr(8'h87, 8'h00);
      chk_n(recals, r0 + 1);
      chk_n(runt, 0);
      prdk(32, 38'h2C0201EB8);
   endtask
   task automatic t_center();
      int r0;
      r0 = recals;
      wr(8'h09, 8'hC2);
      wr(8'h08, 8'hC3);
      chk_n(recals, r0);
      wr(8'h08, 8'hC2);
      prdk(32, 38'h2C2201EB8);
   endtask
   task automatic t_freeze();
      int r0;
      r0 = recals;
      wr(8'h89, 8'h10);
      wr(8'h07, 8'h21);
      wr(8'h87, 8'h40);
      chk_n(recals, r0);
      wr(8'h89, 8'h00);
      chk_n(recals, r0 + 1);
      rdc(8'h87, 8'h00);
      prdk(40, 38'h2C2201EB8);
   endtask
   task automatic finish_test();
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk_i);
      bad_count++;
      finish_test();
   end
   initial begin
      rst();
      t_default();
      t_small();
      t_hold();
      t_center();
      t_freeze();
      @(negedge mclk_i);
      rst();
      chk8({6'h00, clk_out_o, recal_busy_o}, 8'h00);
      rdc(8'h07, 8'h01);
      rdc(8'h09, 8'hBC);
      prdk(32, DEF_FRACTIONAL_MULTIPLIER);
      finish_test();
   end
endmodule // oscillator_freq_programming_tb
`default_nettype wire
